// ### shared/sync_out_pkg.sv
// constants for the sync output and standby control block
package sync_out_pkg;
    // register offsets
    localparam logic [7:0]  ADDR_ACT     = 8'h01;
    localparam logic [7:0]  ADDR_POL     = 8'h02;
    localparam logic [7:0]  ADDR_INCFG   = 8'h05;
    localparam logic [7:0]  ADDR_LS_POL  = 8'h18;
    localparam logic [7:0]  ADDR_LS_WID  = 8'h19;
    localparam logic [7:0]  ADDR_PWR     = 8'h1B;
    localparam logic [7:0]  ADDR_MULT    = 8'h2B;
    localparam logic [7:0]  ADDR_LLEN_LO = 8'h3E;
    localparam logic [7:0]  ADDR_LLEN_HI = 8'h3F;
    // field positions and codes
    localparam int          INCFG_CS_BIT  = 3;
    localparam int          INCFG_SOG_BIT = 4;
    localparam int          LS_POL_BIT    = 7;
    localparam logic [7:0]  PWR_STANDBY   = 8'h0F;
    // reset values: ac-coupled rgb, separate syncs
    localparam logic [7:0]  RST_INCFG  = 8'h00;
    localparam logic [7:0]  RST_LS_POL = 8'h00;
    localparam logic [7:0]  RST_LS_WID = 8'h01;
    localparam logic [7:0]  RST_PWR    = 8'h00;
    localparam logic [7:0]  RST_MULT   = 8'h10;
    localparam logic [11:0] RST_LLEN   = 12'h320;
    // timing
    localparam int          CLK_MHZ        = 25;
    localparam int          EQ_MAX_NS      = 3500;
    localparam int          BROAD_MIN_NS   = 10000;
    localparam int          ACT_TIMEOUT_US = 40000;
    localparam int          EQ_MAX_CYC     = EQ_MAX_NS * CLK_MHZ / 1000;
    localparam int          BROAD_MIN_CYC  = (BROAD_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int          ACT_TIMEOUT_CYC = ACT_TIMEOUT_US * CLK_MHZ;
    localparam int          PW_W           = 10;
    // extracted vertical sync states
    typedef enum logic [1:0] {
        VX_LINE = 2'b01,
        VX_VERT = 2'b10
    } vext_state_t;
endpackage : sync_out_pkg

// ### rtl/sync_monitor.sv
// activity, polarity and pulse width monitor for one sync input
module sync_monitor #(
    parameter logic [19:0] ACT_TIMEOUT_CYC = 20'(sync_out_pkg::ACT_TIMEOUT_CYC)
) (
    input  wire logic                         mclk,
    input  wire logic                         rst_b,
    input  wire logic                         sync_in,
    output logic                              active,
    output logic                              pol_high,
    output logic                              low_done,
    output logic [sync_out_pkg::PW_W-1:0]     low_len
);
    logic [2:0]                      sync_ff;
    logic                            lvl_ff;
    logic                            done_ff;
    logic [sync_out_pkg::PW_W-1:0]   run_ff;
    logic [sync_out_pkg::PW_W-1:0]   hi_len_ff;
    logic [sync_out_pkg::PW_W-1:0]   lo_len_ff;
    logic [19:0]                     idle_ff;
    logic [1:0]                      fill_ff;
    logic                            edge_seen;

    // a change counts once stages two and three agree, after the stages have filled
    assign edge_seen = (fill_ff == 2'h3) && (sync_ff[1] == sync_ff[2]) && (sync_ff[2] != lvl_ff);

    // three stage synchroniser; the level follows the pin while the stages fill,
    // so a pin that idles high gives no false edge after reset
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sync_ff <= 3'h0;
            lvl_ff  <= 1'b0;
            fill_ff <= 2'h0;
        end else begin
            sync_ff <= {sync_ff[1:0], sync_in};
            if (fill_ff != 2'h3) begin
                fill_ff <= fill_ff + 2'h1;
                lvl_ff  <= sync_ff[1];
            end else if (edge_seen) begin
                lvl_ff <= sync_ff[2];
            end
        end
    end

    // phase length measurement, saturating
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            run_ff    <= '0;
            hi_len_ff <= '0;
            lo_len_ff <= '0;
            done_ff   <= 1'b0;
        end else begin
            done_ff <= edge_seen && !lvl_ff;
            if (edge_seen) begin
                run_ff <= 10'h001;
                if (lvl_ff) begin
                    hi_len_ff <= run_ff;
                end else begin
                    lo_len_ff <= run_ff;
                end
            end else if (run_ff != '1) begin
                run_ff <= run_ff + 10'h001;
            end
        end
    end

    // activity timeout keeps running in standby
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            idle_ff <= ACT_TIMEOUT_CYC;
        end else if (edge_seen) begin
            idle_ff <= 20'h00000;
        end else if (idle_ff < ACT_TIMEOUT_CYC) begin
            idle_ff <= idle_ff + 20'h00001;
        end
    end

    assign active   = idle_ff < ACT_TIMEOUT_CYC;
    assign pol_high = hi_len_ff < lo_len_ff;
    assign low_done = done_ff;
    assign low_len  = lo_len_ff;

    AST_MON_ACTIVE: assert property (@(posedge mclk) disable iff (!rst_b)
        edge_seen |=> active ##1 active)
        else $error("activity not shown after a sync edge");
endmodule : sync_monitor

// ### rtl/sync_output_ctrl.sv
// sync outputs, line start pulse generation and standby/reset control
// Contract
// - sync outputs are unsynchronised copies of selected inputs, timing unchanged
// - with sync-on-green selected and INCFG_CS_BIT clear, horizontal output carries the whole composite
// - with sync-on-green selected and INCFG_CS_BIT clear, vertical output is the extracted vertical pulse
// - protection pulses may lengthen or add an extracted vertical pulse
// - line start pulse follows pixel clock and data, ends at pixel 0
// - line start width in pixel clocks equals the width register, at most line length minus one
// - line start polarity comes from bit 7 at line_start_polarity_control
// - wider pulse keeps trailing edge at pixel 0, leading edge moves earlier
// - sync outputs and separator keep running in power down
// - writing 0x0F to power_down_control enters standby, stopping converters and clocks
// - register access and activity/polarity status keep working in standby
// - reference is input clock times multiplier register, host picks near 400MHz
// - power-on reset restores every register default
// - external reset does the same full reset, may stay high
// - reset defaults select ac-coupled rgb input
module sync_output_ctrl #(
    parameter logic [19:0] ACT_TIMEOUT_CYC = 20'(sync_out_pkg::ACT_TIMEOUT_CYC)
) (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        hsync_in,
    input  wire logic        vsync_in,
    input  wire logic        sync_on_green_input,
    input  wire logic        pixel_clock_in,
    input  wire logic [23:0] pixel_data_in,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             hsync_out,
    output logic             vsync_out,
    output logic             line_start_pulse,
    output logic             pixel_clock_out,
    output logic      [23:0] pixel_data_out,
    output logic             adc_power_down,
    output logic             sampling_clock_synth_en,
    output logic      [7:0]  ref_mult
);
    // configuration registers
    logic [7:0]  incfg_ff;
    logic [7:0]  ls_pol_ff;
    logic [7:0]  ls_wid_ff;
    logic [7:0]  pwr_ff;
    logic [7:0]  mult_ff;
    logic [11:0] llen_ff;
    logic [7:0]  rdata_ff;
    // pixel domain sampling
    logic [2:0]  pclk_ff;
    logic        pclk_lvl_ff;
    logic [11:0] pix_cnt_ff;
    logic        ls_act_ff;
    logic        ls_out_ff;
    logic        pclk_out_ff;
    logic [23:0] pdata_ff;
    logic        standby_ff;
    logic        adc_pd_ff;
    logic        synth_en_ff;
    // sync separation
    sync_out_pkg::vext_state_t vx_state_ff;
    logic        vext_ff;
    logic [2:0]  act;
    logic [2:0]  pol;
    logic [2:0]  done;
    logic [sync_out_pkg::PW_W-1:0] len [3];
    logic        sog_sel;
    logic        cs_sel;
    logic        pclk_rise;
    logic [11:0] nxt_pix_cnt;
    logic        nxt_ls_act;
    logic        ls_pol;
    logic [2:0]  raw_in;

    // true while the next pixel lies in the last wid pixels before pixel 0
    function automatic logic in_pulse(input logic [11:0] cnt, input logic [11:0] len_q,
                                      input logic [7:0] wid);
        logic [11:0] w;
        w = (12'(wid) > len_q) ? len_q : 12'(wid);
        in_pulse = (w != 12'h000) && (cnt != 12'h000) && (cnt >= len_q - w);
    endfunction : in_pulse

    assign sog_sel = incfg_ff[sync_out_pkg::INCFG_SOG_BIT];
    assign cs_sel  = incfg_ff[sync_out_pkg::INCFG_CS_BIT];
    assign ls_pol  = ls_pol_ff[sync_out_pkg::LS_POL_BIT];
    assign raw_in  = {sync_on_green_input, vsync_in, hsync_in};

    // one monitor per sync input, all alive in standby
    for (genvar i = 0; i < 3; i++) begin : g_mon
        sync_monitor #(
            .ACT_TIMEOUT_CYC (ACT_TIMEOUT_CYC)
        ) u_mon (
            .mclk     (mclk),
            .rst_b    (rst_b),
            .sync_in  (raw_in[i]),
            .active   (act[i]),
            .pol_high (pol[i]),
            .low_done (done[i]),
            .low_len  (len[i])
        );
    end

    // register writes; one reset serves power-on and external reset
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            incfg_ff  <= sync_out_pkg::RST_INCFG;
            ls_pol_ff <= sync_out_pkg::RST_LS_POL;
            ls_wid_ff <= sync_out_pkg::RST_LS_WID;
            pwr_ff    <= sync_out_pkg::RST_PWR;
            mult_ff   <= sync_out_pkg::RST_MULT;
            llen_ff   <= sync_out_pkg::RST_LLEN;
        end else if (reg_wr) begin
            case (reg_addr)
                sync_out_pkg::ADDR_INCFG:   incfg_ff  <= reg_wdata;
                sync_out_pkg::ADDR_LS_POL:  ls_pol_ff <= reg_wdata;
                sync_out_pkg::ADDR_LS_WID:  ls_wid_ff <= reg_wdata;
                sync_out_pkg::ADDR_PWR:     pwr_ff    <= reg_wdata;
                sync_out_pkg::ADDR_MULT:    mult_ff   <= reg_wdata;
                sync_out_pkg::ADDR_LLEN_LO: llen_ff[7:0]  <= reg_wdata;
                sync_out_pkg::ADDR_LLEN_HI: llen_ff[11:8] <= reg_wdata[3:0];
                default: ;
            endcase
        end
    end

    // register reads, answered one cycle later, also in standby
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                sync_out_pkg::ADDR_ACT:     rdata_ff <= {5'h00, act};
                sync_out_pkg::ADDR_POL:     rdata_ff <= {5'h00, pol};
                sync_out_pkg::ADDR_INCFG:   rdata_ff <= incfg_ff;
                sync_out_pkg::ADDR_LS_POL:  rdata_ff <= ls_pol_ff;
                sync_out_pkg::ADDR_LS_WID:  rdata_ff <= ls_wid_ff;
                sync_out_pkg::ADDR_PWR:     rdata_ff <= pwr_ff;
                sync_out_pkg::ADDR_MULT:    rdata_ff <= mult_ff;
                sync_out_pkg::ADDR_LLEN_LO: rdata_ff <= llen_ff[7:0];
                sync_out_pkg::ADDR_LLEN_HI: rdata_ff <= {4'h0, llen_ff[11:8]};
                default:                    rdata_ff <= 8'h00;
            endcase
        end
    end

    // standby decode drives converter and synthesiser enables
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            standby_ff  <= 1'b0;
            adc_pd_ff   <= 1'b0;
            synth_en_ff <= 1'b1;
        end else begin
            standby_ff  <= pwr_ff == sync_out_pkg::PWR_STANDBY;
            adc_pd_ff   <= pwr_ff == sync_out_pkg::PWR_STANDBY;
            synth_en_ff <= pwr_ff != sync_out_pkg::PWR_STANDBY;
        end
    end

    // pixel clock sampled by three stages, edge taken when stages agree
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pclk_ff     <= 3'h0;
            pclk_lvl_ff <= 1'b0;
        end else begin
            pclk_ff <= {pclk_ff[1:0], pixel_clock_in};
            if (pclk_ff[1] == pclk_ff[2]) begin
                pclk_lvl_ff <= pclk_ff[2];
            end
        end
    end

    assign pclk_rise = !standby_ff && (pclk_ff[1] == pclk_ff[2]) && pclk_ff[2] && !pclk_lvl_ff;

    // next pixel position and line start state
    always_comb begin
        nxt_pix_cnt = pix_cnt_ff;
        nxt_ls_act  = ls_act_ff;
        if (pclk_rise) begin
            nxt_pix_cnt = (pix_cnt_ff >= llen_ff - 12'h001) ? 12'h000 : pix_cnt_ff + 12'h001;
            nxt_ls_act  = in_pulse(nxt_pix_cnt, llen_ff, ls_wid_ff);
        end
    end

    // pixel counter and line start, held still in standby
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pix_cnt_ff <= 12'h000;
            ls_act_ff  <= 1'b0;
            ls_out_ff  <= 1'b0;
        end else begin
            pix_cnt_ff <= nxt_pix_cnt;
            ls_act_ff  <= nxt_ls_act;
            ls_out_ff  <= nxt_ls_act ^ ls_pol;
        end
    end

    // pixel data leaves on the same edge as the line start, pixel clock one cycle later
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pclk_out_ff <= 1'b0;
            pdata_ff    <= 24'h000000;
        end else begin
            pclk_out_ff <= !standby_ff && pclk_lvl_ff;
            if (pclk_rise) begin
                pdata_ff <= pixel_data_in;
            end
        end
    end

    // vertical extraction from sync-on-green pulse widths
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            vx_state_ff <= sync_out_pkg::VX_LINE;
        end else if (done[2]) begin
            case (vx_state_ff)
                sync_out_pkg::VX_LINE: begin
                    if (len[2] <= 10'(sync_out_pkg::EQ_MAX_CYC) ||
                        len[2] >= 10'(sync_out_pkg::BROAD_MIN_CYC)) begin
                        vx_state_ff <= sync_out_pkg::VX_VERT;
                    end
                end
                sync_out_pkg::VX_VERT: begin
                    if (len[2] > 10'(sync_out_pkg::EQ_MAX_CYC) &&
                        len[2] < 10'(sync_out_pkg::BROAD_MIN_CYC)) begin
                        vx_state_ff <= sync_out_pkg::VX_LINE;
                    end
                end
                default: vx_state_ff <= sync_out_pkg::VX_LINE;
            endcase
        end
    end

    // extracted vertical sync, active low like the sync tip
    assign vext_ff = vx_state_ff != sync_out_pkg::VX_VERT;

    // unsynchronised pass-through, or the extracted vertical on vsync_out with sync-on-green selected and INCFG_CS_BIT clear, independent of standby
    assign hsync_out = (sog_sel && !cs_sel) ? sync_on_green_input : hsync_in;
    assign vsync_out = (sog_sel && !cs_sel) ? vext_ff : vsync_in;

    assign reg_rdata               = rdata_ff;
    assign line_start_pulse        = ls_out_ff;
    assign pixel_clock_out         = pclk_out_ff;
    assign pixel_data_out          = pdata_ff;
    assign adc_power_down          = adc_pd_ff;
    assign sampling_clock_synth_en = synth_en_ff;
    assign ref_mult                = mult_ff;

    // helper: first cycle after reset release
    logic rst_seen_ff;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_seen_ff <= 1'b0;
        end else begin
            rst_seen_ff <= 1'b1;
        end
    end

    AST_RESET_DEFAULTS: assert property (@(posedge mclk) disable iff (!rst_b)
        !rst_seen_ff |-> incfg_ff == sync_out_pkg::RST_INCFG && pwr_ff == sync_out_pkg::RST_PWR
                         && !ls_act_ff && synth_en_ff)
        else $error("defaults not present after reset");
    AST_STANDBY_HOLDS: assert property (@(posedge mclk) disable iff (!rst_b)
        standby_ff |-> adc_power_down ##1 ($stable(pix_cnt_ff) && !pixel_clock_out))
        else $error("pixel logic moved in standby");
    AST_STANDBY_ENTRY: assert property (@(posedge mclk) disable iff (!rst_b)
        reg_wr && reg_addr == sync_out_pkg::ADDR_PWR && reg_wdata == sync_out_pkg::PWR_STANDBY
        |=> ##1 standby_ff && !sampling_clock_synth_en)
        else $error("standby not entered two cycles after write");
    AST_LEAD_EDGE: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(ls_act_ff) |-> pix_cnt_ff == llen_ff - 12'(ls_wid_ff) || 12'(ls_wid_ff) >= llen_ff)
        else $error("line start began at wrong pixel");
    AST_TRAIL_PIX0: assert property (@(posedge mclk) disable iff (!rst_b)
        $fell(ls_act_ff) && $stable(llen_ff) && $stable(ls_wid_ff) |-> pix_cnt_ff == 12'h000)
        else $error("line start did not end at pixel 0");
    AST_POLARITY: assert property (@(posedge mclk) disable iff (!rst_b)
        line_start_pulse == (ls_act_ff ^ $past(ls_pol)))
        else $error("line start polarity wrong");
    AST_SOG_PASS: assert property (@(posedge mclk) disable iff (!rst_b)
        sog_sel && !cs_sel && standby_ff |-> hsync_out == sync_on_green_input)
        else $error("composite not passed in standby");
    AST_VEXT_SET: assert property (@(posedge mclk) disable iff (!rst_b)
        done[2] && len[2] >= 10'(sync_out_pkg::BROAD_MIN_CYC) |=> !vext_ff)
        else $error("broad pulse did not start extracted vertical");
    AST_VEXT_CLR: assert property (@(posedge mclk) disable iff (!rst_b)
        done[2] && len[2] > 10'(sync_out_pkg::EQ_MAX_CYC) && len[2] < 10'(sync_out_pkg::BROAD_MIN_CYC)
        |=> vext_ff)
        else $error("line pulse did not end extracted vertical");
    AST_STATUS_READ: assert property (@(posedge mclk) disable iff (!rst_b)
        reg_rd && reg_addr == sync_out_pkg::ADDR_ACT |=> reg_rdata == {5'h00, $past(act)})
        else $error("activity status read wrong");

    COV_LINE_START: cover property (@(posedge mclk) disable iff (!rst_b) $fell(ls_act_ff));
    COV_STANDBY:    cover property (@(posedge mclk) disable iff (!rst_b) $rose(standby_ff));
    COV_VEXT:       cover property (@(posedge mclk) disable iff (!rst_b) $fell(vext_ff) && sog_sel);
endmodule : sync_output_ctrl

// ### dv/pixel_link_partner.sv
// downstream scaler model: makes the pixel clock and data, captures line start and data
module pixel_link_partner (
    input  wire logic        mclk,
    input  wire logic        en,
    input  wire logic        pixel_clock_out,
    input  wire logic        line_start_pulse,
    input  wire logic [23:0] pixel_data_out,
    output logic             pixel_clock_in,
    output logic      [23:0] pixel_data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] sent_q[$];
    logic [23:0] dat_q[$];
    logic        ls_q[$];
    logic        prev_ff = 1'b0;

    // 320 ns pixel clock, still between frames; data moves well clear of the capture point
    initial begin
        pixel_clock_in = 1'b0;
        pixel_data_in  = 24'h000001;
        #7;
        forever begin
            if (en) begin
                pixel_clock_in = 1'b1;
                sent_q.push_back(pixel_data_in);
                #160;
                pixel_clock_in = 1'b0;
                #80;
                pixel_data_in = pixel_data_in * 24'h000005 + 24'h0A5A51;
                #80;
            end else begin
                #13;
            end
        end
    end

    // capture on each output pixel clock rise, after that edge's updates have landed
    always @(negedge mclk) begin
        if (pixel_clock_out && !prev_ff) begin
            ls_q.push_back(line_start_pulse);
            dat_q.push_back(pixel_data_out);
        end
        prev_ff <= pixel_clock_out;
    end

    function automatic void flush();
        sent_q.delete();
        dat_q.delete();
        ls_q.delete();
    endfunction : flush
endmodule : pixel_link_partner

// ### dv/tb.sv
// self-checking bench for the sync output and standby control block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0, rst_b = 1'b0, hsync_in = 1'b0, vsync_in = 1'b0, sog = 1'b1;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, pen = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, v, cfg;
    logic [7:0]  reg_rdata, ref_mult;
    logic [23:0] pixel_data_in, pixel_data_out;
    logic        pixel_clock_in, hsync_out, vsync_out, line_start_pulse, pixel_clock_out;
    logic        adc_power_down, sampling_clock_synth_en, hi;
    int          fail_count = 0, n_tests = 0, seed = 5351, len = 8, k, i;
    logic [7:0]  a_tab[5] = '{8'h05, 8'h18, 8'h19, 8'h1B, 8'h77};
    logic [7:0]  d_tab[5] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
    logic [7:0]  cfg_tab[4] = '{8'h00, 8'h08, 8'h10, 8'h18};
    int          low_tab[4] = '{300, 150, 40, 150};

    always #20 mclk = ~mclk;

    sync_output_ctrl #(.ACT_TIMEOUT_CYC(20'd2000)) dut (
        .mclk(mclk), .rst_b(rst_b), .hsync_in(hsync_in), .vsync_in(vsync_in),
        .sync_on_green_input(sog), .pixel_clock_in(pixel_clock_in), .pixel_data_in(pixel_data_in),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .hsync_out(hsync_out), .vsync_out(vsync_out),
        .line_start_pulse(line_start_pulse), .pixel_clock_out(pixel_clock_out),
        .pixel_data_out(pixel_data_out), .adc_power_down(adc_power_down),
        .sampling_clock_synth_en(sampling_clock_synth_en), .ref_mult(ref_mult));

    pixel_link_partner ps (
        .mclk(mclk), .en(pen), .pixel_clock_out(pixel_clock_out), .line_start_pulse(line_start_pulse),
        .pixel_data_out(pixel_data_out), .pixel_clock_in(pixel_clock_in), .pixel_data_in(pixel_data_in));

    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cyc(1);
        reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
        cyc(1);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        cyc(1);
        reg_rd = 1'b1; reg_addr = a;
        cyc(1);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask : rd

    task automatic do_reset();
        cyc(1);
        rst_b = 1'b0;
        cyc(2);
        rst_b = 1'b1;
    endtask : do_reset

    // one line start case: model counts pixels 0..len-1, active on the last w before pixel 0
    task automatic line_case(input int w, input logic pol);
        int  c;
        logic e;
        cyc(20);
        do_reset();
        wr(sync_out_pkg::ADDR_LLEN_LO, 8'(len));
        wr(sync_out_pkg::ADDR_LLEN_HI, 8'h00);
        wr(sync_out_pkg::ADDR_LS_WID, 8'(w));
        wr(sync_out_pkg::ADDR_LS_POL, {pol, 7'h00});
        ps.flush();
        pen = 1'b1;
        for (k = 0; k < 600 && ps.ls_q.size() < 2 * len; k++) cyc(1);
        pen = 1'b0;
        chk(24'(ps.ls_q.size() >= 2 * len), 24'h1, "pixel clock stalled");
        c = 0;
        for (int j = 0; j < 2 * len && j < ps.ls_q.size(); j++) begin
            c = (c + 1) % len;
            e = ((c != 0) && (c >= len - w)) ^ pol;
            chk(24'(ps.ls_q[j]), 24'(e), "line start level");
            chk(ps.dat_q[j], ps.sent_q[j], "pixel data");
        end
    endtask : line_case

    task automatic stop_test();
        $display("fail_count=%0d n_tests=%0d", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test

    // watchdog well beyond the expected run of about 4400 cycles
    initial begin
        #2ms;
        fail_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        stop_test();
    end

    initial begin
        repeat (5) @(posedge mclk);
        #1;
        rst_b = 1'b1;
        // defaults and an unmapped place
        chk(ref_mult, sync_out_pkg::RST_MULT, "ref_mult default");
        chk(adc_power_down, 1'b0, "power down default");
        chk(sampling_clock_synth_en, 1'b1, "synth default");
        for (i = 0; i < 5; i++) begin
            rd(a_tab[i], v);
            chk(v, d_tab[i], "register default");
        end
        wr(8'h77, 8'h5A);
        rd(8'h77, v);
        chk(v, 8'h00, "unmapped read");
        // multiplier write goes out to the reference port and reads back
        v = 8'($random(seed));
        wr(sync_out_pkg::ADDR_MULT, v);
        cyc(2);
        chk(ref_mult, v, "ref_mult port");
        rd(sync_out_pkg::ADDR_MULT, cfg);
        chk(cfg, v, "multiplier readback");
        wr(sync_out_pkg::ADDR_LS_WID, 8'h07);
        do_reset();
        chk(ref_mult, sync_out_pkg::RST_MULT, "ref_mult after reset");
        rd(sync_out_pkg::ADDR_LS_WID, v);
        chk(v, sync_out_pkg::RST_LS_WID, "width after reset");
        // pass-through for every source selection
        for (i = 0; i < 4; i++) begin
            cfg = cfg_tab[i];
            wr(sync_out_pkg::ADDR_INCFG, cfg);
            for (k = 0; k < 16; k++) begin
                @(posedge mclk);
                #1;
                {hsync_in, vsync_in, sog} = 3'($random(seed));
                #5;
                chk(hsync_out, (cfg == 8'h10) ? sog : hsync_in, "hsync out");
                if (cfg != 8'h10) chk(vsync_out, vsync_in, "vsync out");
            end
        end
        // extracted vertical: broad and equalising pulses enter it, line-length pulses leave it
        wr(sync_out_pkg::ADDR_INCFG, 8'h10);
        sog = 1'b1;
        cyc(100);
        for (i = 0; i < 4; i++) begin
            sog = 1'b0;
            cyc(low_tab[i]);
            sog = 1'b1;
            cyc(6);
            chk(vsync_out, (low_tab[i] == 150) ? 1'b1 : 1'b0, "extracted vertical");
            cyc(100);
        end
        // line start cases: single, wider with low polarity, none, clamped to line length
        line_case(1, 1'b0);
        line_case(3, 1'b1);
        line_case(0, 1'b0);
        line_case(9, 1'b1);
        line_case(int'($random(seed) & 7), 1'b0);
        // standby: one off is not standby, the exact code is
        wr(sync_out_pkg::ADDR_PWR, 8'h0E);
        cyc(3);
        chk(adc_power_down, 1'b0, "near standby code");
        wr(sync_out_pkg::ADDR_PWR, sync_out_pkg::PWR_STANDBY);
        cyc(3);
        chk({adc_power_down, sampling_clock_synth_en}, 2'b10, "standby enables");
        pen = 1'b1;
        hi = 1'b0;
        for (k = 0; k < 100; k++) begin
            hsync_in = (k % 8) < 2;
            cyc(1);
            hi = hi | pixel_clock_out;
            chk(hsync_out, hsync_in, "hsync in standby");
        end
        pen = 1'b0;
        chk(hi, 1'b0, "pixel clock frozen");
        rd(sync_out_pkg::ADDR_ACT, v);
        chk(v[0], 1'b1, "hsync activity in standby");
        rd(sync_out_pkg::ADDR_POL, v);
        chk(v[0], 1'b1, "hsync polarity in standby");
        rd(sync_out_pkg::ADDR_PWR, v);
        chk(v, 8'h0F, "register read in standby");
        cyc(2100);
        rd(sync_out_pkg::ADDR_ACT, v);
        chk(v[0], 1'b0, "hsync activity timeout");
        wr(sync_out_pkg::ADDR_PWR, 8'h00);
        cyc(3);
        chk({adc_power_down, sampling_clock_synth_en}, 2'b01, "leave standby");
        ps.flush();
        pen = 1'b1;
        for (k = 0; k < 200 && ps.ls_q.size() < 2; k++) cyc(1);
        pen = 1'b0;
        chk(24'(ps.ls_q.size() >= 2), 24'h1, "pixel clock resumes");
        cyc(20);
        stop_test();
    end
endmodule : tb
